// ### hdl/autoneg_ability_registers.sv
`timescale 1ns/100ps
module autoneg_ability_registers import an_regs_pkg::*; (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic hardware_software_select_pin_i,
	input wire logic an_enable_strap_i,
	input wire logic link_fault_i,
	input wire logic [15:0] rx_code_word_i,
	input wire logic rx_word_valid_i,
	input wire logic an_complete_i,
	output logic [15:0] tx_code_word_o,
	output logic an_enable_o,
	output logic an_restart_o,
	output logic idle_symbols_o,
	output logic speed_100_o,
	output logic full_duplex_o
);
	typedef struct packed {
		logic [1:0] strap_count;
		logic strap_done;
		logic an_enable;
		logic speed_100;
		logic full_duplex;
		logic restart;
		logic override;
		logic next_page;
		logic resv14;
		logic remote_fault;
		logic [2:0] resv;
		logic [3:0] technology_ability_field;
		logic [4:0] selector;
		logic [15:0] partner;
		logic [15:0] tx_word;
		logic idle_symbols;
	} core_state_t;

	localparam core_state_t CORE_RESET = '{
		strap_count: 2'h0,
		strap_done: 1'b0,
		an_enable: RST_AN_ENABLE,
		speed_100: RST_SPEED_100,
		full_duplex: RST_FULL_DUPLEX,
		restart: 1'b0,
		override: RST_OVERRIDE,
		next_page: RST_NEXT_PAGE,
		resv14: RST_RESV14,
		remote_fault: 1'b0,
		resv: RST_RESV,
		technology_ability_field: RST_TAF_AN,
		selector: RST_SELECTOR,
		partner: RST_PARTNER,
		tx_word: 16'h0000,
		idle_symbols: 1'b0
	};

	core_state_t s_reg;
	core_state_t s_next;
	logic [1:0] strap_sync;
	logic hw_mode;
	logic strap_an_enable;
	logic wr_control;
	logic wr_advert;
	logic wr_override;

	reg_if rb();

	ahb_reg_port u_port (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hready_i),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.rb(rb.bus)
	);

	// Straps are pins, so they cross two flops before use
	pin_sync #(.W(2)) u_strap_sync (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.async_i({hardware_software_select_pin_i, an_enable_strap_i}),
		.sync_o(strap_sync)
	);

	assign hw_mode = strap_sync[1];
	assign strap_an_enable = strap_sync[0];

	// Advertisement word as seen by software or as sent on the wire
	function automatic logic [15:0] advert_word(input core_state_t st,
		input logic for_read);
		logic [15:0] w;
		w = 16'h0000;
		w[BIT_NEXT_PAGE] = st.next_page;
		w[BIT_ACK] = for_read ? 1'b0 : st.resv14;
		w[BIT_REMOTE_FAULT] = st.remote_fault;
		// Stored reserved bits still reach the wire for aux use
		w[RESV_HI:RESV_LO] = for_read ? 3'h0 : st.resv;
		w[BIT_T4] = 1'b0;
		w[TAF_HI:TAF_LO] = st.technology_ability_field;
		w[SEL_HI:SEL_LO] = st.selector;
		return w;
	endfunction

	// Partner word as kept in the read-only register
	function automatic logic [15:0] partner_word(input logic [15:0] rx);
		logic [15:0] w;
		w = rx;
		w[RESV_HI:RESV_LO] = 3'h0;
		w[BIT_T4] = 1'b0;
		return w;
	endfunction

	// Register map; unmapped or refused accesses read zero
	always_comb begin
		rb.rdata = 16'h0000;
		if (rb.hit) begin
			unique case (rb.idx)
				IDX_CONTROL: begin
					rb.rdata[BIT_SPEED_100] = s_reg.speed_100;
					rb.rdata[BIT_AN_ENABLE] = s_reg.an_enable;
					rb.rdata[BIT_FULL_DUPLEX] = s_reg.full_duplex;
				end
				IDX_STATUS: begin
					// Fixed capabilities, independent of advertisement
					rb.rdata = STATUS_FIXED;
					rb.rdata[BIT_STAT_COMPLETE] = an_complete_i;
				end
				IDX_ADVERT: begin
					rb.rdata = advert_word(s_reg, 1'b1);
				end
				IDX_PARTNER: begin
					rb.rdata = s_reg.partner;
				end
				IDX_OVERRIDE: begin
					rb.rdata[BIT_OVERRIDE] = s_reg.override;
				end
				IDX_AN_SUMMARY: begin
					rb.rdata[BIT_SUM_COMPLETE] = an_complete_i;
				end
				default: begin
					rb.rdata = 16'h0000;
				end
			endcase
		end
	end

	assign wr_control = rb.wr_en && (rb.idx == IDX_CONTROL);
	assign wr_advert = rb.wr_en && (rb.idx == IDX_ADVERT);
	assign wr_override = rb.wr_en && (rb.idx == IDX_OVERRIDE);

	always_comb begin
		s_next = s_reg;
		s_next.restart = 1'b0;

		// Fault indication is live, so software writes cannot mask it
		s_next.remote_fault = link_fault_i;

		// Defaults loaded once the strap synchroniser has settled
		if (!s_reg.strap_done) begin
			s_next.strap_count = s_reg.strap_count + 2'h1;
			if (s_reg.strap_count == STRAP_SETTLE_CYCLES) begin
				s_next.strap_done = 1'b1;
				s_next.an_enable = hw_mode ? strap_an_enable :
					RST_AN_ENABLE;
				if (hw_mode && !strap_an_enable) begin
					s_next.technology_ability_field = RST_TAF_FORCED;
				end else begin
					s_next.technology_ability_field = RST_TAF_AN;
				end
			end
		end

		if (wr_control) begin
			s_next.speed_100 = rb.wdata[BIT_SPEED_100];
			s_next.an_enable = rb.wdata[BIT_AN_ENABLE];
			s_next.full_duplex = rb.wdata[BIT_FULL_DUPLEX];
			// Restart is a one-cycle request, reads back as zero
			s_next.restart = rb.wdata[BIT_AN_RESTART];
		end

		if (wr_override) begin
			s_next.override = rb.wdata[BIT_OVERRIDE];
		end

		if (wr_advert) begin
			s_next.next_page = rb.wdata[BIT_NEXT_PAGE];
			if (s_reg.override) begin
				s_next.resv14 = rb.wdata[BIT_ACK];
				s_next.resv = rb.wdata[RESV_HI:RESV_LO];
				s_next.technology_ability_field = rb.wdata[TAF_HI:TAF_LO];
				s_next.selector = rb.wdata[SEL_HI:SEL_LO];
			end
		end

		// Partner word carries next page, acknowledge and abilities
		if (rx_word_valid_i) begin
			s_next.partner = partner_word(rx_code_word_i);
			// Bits 15 and 14 are kept as received
		end

		// Enable off: no negotiation, idle_symbols sent, forced mode applies
		s_next.idle_symbols = s_reg.strap_done && !s_next.an_enable;

		// Code word follows the stored advertisement every cycle
		s_next.tx_word = advert_word(s_next, 1'b0);
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			s_reg <= CORE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tx_code_word_o = s_reg.tx_word;
	assign an_enable_o = s_reg.an_enable;
	assign an_restart_o = s_reg.restart;
	assign idle_symbols_o = s_reg.idle_symbols;
	assign speed_100_o = s_reg.speed_100;
	assign full_duplex_o = s_reg.full_duplex;
endmodule

// ### hdl/an_regs_pkg.sv
package an_regs_pkg;
	localparam int REG_W = 16;
	localparam int IDX_W = 8;

	// Register indexes; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CONTROL = 8'h00;
	localparam logic [IDX_W-1:0] IDX_STATUS = 8'h01;
	localparam logic [IDX_W-1:0] IDX_ADVERT = 8'h04;
	localparam logic [IDX_W-1:0] IDX_PARTNER = 8'h05;
	localparam logic [IDX_W-1:0] IDX_OVERRIDE = 8'h10;
	localparam logic [IDX_W-1:0] IDX_AN_SUMMARY = 8'h11;

	// Control, status, override and summary fields
	localparam int BIT_SPEED_100 = 13;
	localparam int BIT_AN_ENABLE = 12;
	localparam int BIT_AN_RESTART = 9;
	localparam int BIT_FULL_DUPLEX = 8;
	localparam int BIT_STAT_COMPLETE = 5;
	localparam int BIT_OVERRIDE = 15;
	localparam int BIT_SUM_COMPLETE = 4;

	// Advertisement and partner word fields
	localparam int BIT_NEXT_PAGE = 15;
	localparam int BIT_ACK = 14;
	localparam int BIT_REMOTE_FAULT = 13;
	localparam int RESV_HI = 12;
	localparam int RESV_LO = 10;
	localparam int BIT_T4 = 9;
	localparam int TAF_HI = 8;
	localparam int TAF_LO = 5;
	localparam int SEL_HI = 4;
	localparam int SEL_LO = 0;

	// Reset values
	localparam logic RST_SPEED_100 = 1'b1;
	localparam logic RST_FULL_DUPLEX = 1'b1;
	localparam logic RST_AN_ENABLE = 1'b1;
	localparam logic RST_OVERRIDE = 1'b0;
	localparam logic RST_NEXT_PAGE = 1'b0;
	localparam logic RST_RESV14 = 1'b0;
	localparam logic [2:0] RST_RESV = 3'h0;
	localparam logic [3:0] RST_TAF_AN = 4'hf;
	localparam logic [3:0] RST_TAF_FORCED = 4'h0;
	localparam logic [4:0] RST_SELECTOR = 5'h01;
	localparam logic [15:0] RST_PARTNER = 16'h0000;
	// Capabilities in bits 14 to 11, bit 3 is auto-negotiation ability
	localparam logic [15:0] STATUS_FIXED = 16'h7808;

	// Edges after reset release before the synchronised straps are valid
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT,
		BUS_READ_DONE
	} bus_phase_t;
endpackage

// ### hdl/reg_if.sv
`timescale 1ns/100ps
interface reg_if import an_regs_pkg::*; ();
	logic hit;
	logic wr_en;
	logic [IDX_W-1:0] idx;
	logic [REG_W-1:0] wdata;
	logic [REG_W-1:0] rdata;

	modport bus(output hit, output wr_en, output idx, output wdata,
		input rdata);
	modport regs(input hit, input wr_en, input idx, input wdata,
		output rdata);
endinterface

// ### hdl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] stage2;
		logic [W-1:0] stage1;
	} sync_state_t;

	sync_state_t s_reg;
	sync_state_t s_next;

	// Only the second stage looks at the first
	always_comb begin
		s_next = s_reg;
		s_next.stage1 = async_i;
		s_next.stage2 = s_reg.stage1;
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_o = s_reg.stage2;
endmodule

// ### hdl/ahb_reg_port.sv
`timescale 1ns/100ps
module ahb_reg_port import an_regs_pkg::*; (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	reg_if.bus rb
);
	typedef struct packed {
		bus_phase_t phase;
		logic [IDX_W-1:0] idx;
		logic hit;
		logic ready;
		logic resp;
		logic [31:0] rdata;
	} port_state_t;

	port_state_t s_reg;
	port_state_t s_next;
	logic accept;
	logic addr_ok;

	assign accept = s_reg.ready && hready_i && hsel_i && htrans_i[1];
	// Word accesses inside the map window only; others read zero
	assign addr_ok = (haddr_i[31:10] == 22'h000000) &&
		(haddr_i[1:0] == 2'h0) && (hsize_i == 3'h2);

	assign rb.idx = s_reg.idx;
	assign rb.hit = s_reg.hit;
	assign rb.wdata = hwdata_i[REG_W-1:0];
	assign rb.wr_en = (s_reg.phase == BUS_WRITE) && s_reg.hit;

	// Reads take one wait state so a write just before is seen
	always_comb begin
		s_next = s_reg;
		s_next.resp = 1'b0;
		unique case (s_reg.phase)
			BUS_READ_WAIT: begin
				s_next.rdata = {16'h0000, rb.rdata};
				s_next.ready = 1'b1;
				s_next.phase = BUS_READ_DONE;
			end
			BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
				s_next.phase = BUS_IDLE;
			end
		endcase
		if (accept) begin
			s_next.idx = haddr_i[IDX_W+1:2];
			s_next.hit = addr_ok;
			s_next.phase = hwrite_i ? BUS_WRITE : BUS_READ_WAIT;
			s_next.ready = hwrite_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			s_reg <= '{phase: BUS_IDLE, idx: '0, hit: 1'b0,
				ready: 1'b1, resp: 1'b0, rdata: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata_o = s_reg.rdata;
	assign hreadyout_o = s_reg.ready;
	assign hresp_o = s_reg.resp;
endmodule

// ### sim/autoneg_regs_sva.sv
`timescale 1ns/100ps
module autoneg_regs_chk (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic link_fault_i,
	input wire logic an_restart_o,
	input wire logic [15:0] tx_code_word_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	logic take;
	assign take = hsel_i && htrans_i[1] && hready_i;
	// The code word is rebuilt from the next state, so one edge of lag
	AST_FAULT_SENT: assert property (
		link_fault_i |=> tx_code_word_o[13]) else $error("fault lost");
	AST_T4_TX: assert property (
		tx_code_word_o[9] == 1'b0) else $error("t4 bit sent");
	AST_READ_WAIT: assert property (
		take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait wrong");
	AST_WRITE_READY: assert property (
		take && hwrite_i |=> hreadyout_o) else $error("write stall");
	AST_ADV_RESV: assert property (
		take && !hwrite_i && haddr_i == 32'h10 |-> ##2
		hrdata_o[14] == 1'b0 && hrdata_o[12:9] == 4'h0)
		else $error("reserved bit read one");
	AST_PART_T4: assert property (
		take && !hwrite_i && haddr_i == 32'h14 |-> ##2
		hrdata_o[12:9] == 4'h0) else $error("partner t4 one");
	AST_UPPER_ZERO: assert property (
		take && !hwrite_i |-> ##2 hrdata_o[31:16] == 16'h0)
		else $error("upper half set");
	AST_RESTART: assert property (
		(take && hwrite_i && haddr_i == 32'h0) ##1 hwdata_i[9]
		|-> ##[1:2] an_restart_o) else $error("no restart");
	cover property (take && !hwrite_i && haddr_i == 32'h14);
	cover property (link_fault_i ##1 tx_code_word_o[13]);
	cover property (an_restart_o);
endmodule
bind autoneg_ability_registers autoneg_regs_chk u_chk (.clock_i, .srst_i,
	.hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
	.hrdata_o, .hreadyout_o, .link_fault_i, .an_restart_o,
	.tx_code_word_o);

// ### sim/link_partner_model.sv
`timescale 1ns/100ps
module link_partner_model (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic send_i,
	input wire logic [7:0] delay_i,
	input wire logic [15:0] word_i,
	output logic [15:0] rx_code_word_o,
	output logic rx_word_valid_o,
	output logic an_complete_o
);
	logic [15:0] last_reg;
	logic [7:0] cnt_reg;
	logic busy_reg;
	always @(posedge clock_i) begin
		rx_word_valid_o <= 1'b0;
		// Idle bus shows the inverted last word so a stale word is never mistaken
		rx_code_word_o <= ~last_reg;
		if (srst_i) begin
			busy_reg <= 1'b0;
			an_complete_o <= 1'b0;
			last_reg <= 16'h0;
		end else if (send_i && !busy_reg) begin
			busy_reg <= 1'b1;
			cnt_reg <= delay_i;
		end else if (busy_reg && cnt_reg != 8'h0) begin
			cnt_reg <= cnt_reg - 8'h1;
		end else if (busy_reg) begin
			busy_reg <= 1'b0;
			rx_word_valid_o <= 1'b1;
			rx_code_word_o <= word_i;
			last_reg <= word_i;
			an_complete_o <= 1'b1;
		end
	end
endmodule

// ### sim/test_autoneg_ability_registers.sv
`timescale 1ns/100ps
module test_autoneg_ability_registers;
	typedef struct packed {
		logic [31:0] a;
		logic [15:0] d;
		logic [15:0] e;
		logic [15:0] t;
	} row_t;
	// Address, write data, read-back, transmitted word
	localparam row_t ROWS[10] = '{
		'{32'h10, 16'h0000, 16'h01e1, 16'h01e1},
		'{32'h40, 16'h8000, 16'h8000, 16'h01e1},
		'{32'h10, 16'hffe2, 16'h81e2, 16'hdde2},
		'{32'h10, 16'h8041, 16'h8041, 16'h8041},
		'{32'h40, 16'h0000, 16'h0000, 16'h8041},
		'{32'h10, 16'h7fe1, 16'h0041, 16'h0041},
		'{32'h00, 16'h3300, 16'h3100, 16'h0041},
		'{32'h04, 16'h0000, 16'h7808, 16'h0041},
		'{32'h14, 16'hffff, 16'h0000, 16'h0041},
		'{32'h3fc, 16'hffff, 16'h0000, 16'h0041}};
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic hw_sel = 1'b0;
	logic link_fault_i = 1'b0;
	logic lp_send = 1'b0;
	logic [7:0] lp_dly = 8'h0;
	logic [15:0] lp_word = 16'h0;
	logic [15:0] rx_word, tx_code_word_o;
	logic rx_valid, an_done, hreadyout_o, hresp_o, an_enable_o;
	logic an_restart_o, idle_symbols_o, speed_100_o, full_duplex_o;
	logic [31:0] hrdata_o, rd_q, q;
	logic rdy_q;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	autoneg_ability_registers u_dut (.clock_i, .srst_i, .hsel_i,
		.haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
		.hardware_software_select_pin_i(hw_sel), .an_enable_strap_i(1'b0),
		.link_fault_i, .rx_code_word_i(rx_word), .rx_word_valid_i(rx_valid),
		.an_complete_i(an_done), .tx_code_word_o, .an_enable_o,
		.an_restart_o, .idle_symbols_o, .speed_100_o, .full_duplex_o);
	link_partner_model u_lp (.clock_i, .srst_i, .send_i(lp_send),
		.delay_i(lp_dly), .word_i(lp_word), .rx_code_word_o(rx_word),
		.rx_word_valid_o(rx_valid), .an_complete_o(an_done));
	always #12.5 clock_i = ~clock_i;
	// Values seen just before the next rising edge
	always @(negedge clock_i) begin
		rdy_q = hreadyout_o;
		rd_q = hrdata_o;
	end
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		do @(posedge clock_i); while (rdy_q !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clock_i); while (rdy_q !== 1'b1);
		q = rd_q;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic rst_dut(input logic sel);
		srst_i <= 1'b1;
		hw_sel <= sel;
		repeat (4) @(posedge clock_i);
		srst_i <= 1'b0;
		// Let the strap defaults land before any write
		repeat (8) @(posedge clock_i);
	endtask
	task automatic send(input logic [15:0] w, input logic [7:0] d);
		lp_word <= w;
		lp_dly <= d;
		lp_send <= 1'b1;
		@(posedge clock_i);
		lp_send <= 1'b0;
		repeat (d + 5) @(posedge clock_i);
	endtask
	initial begin
		rst_dut(1'b0);
		for (int i = 0; i < 10; i++) begin
			bus(1'b1, ROWS[i].a, {16'h0, ROWS[i].d});
			rd(ROWS[i].a, {16'h0, ROWS[i].e});
			chk({16'h0, tx_code_word_o}, {16'h0, ROWS[i].t});
		end
		chk({31'h0, hresp_o}, 32'h0);
		$display("register rows done");
		send(16'hffff, 8'd0);
		rd(32'h14, 32'he1ff);
		rd(32'h04, 32'h7828);
		rd(32'h44, 32'h0010);
		send(16'h41a1, 8'd20);
		rd(32'h14, 32'h41a1);
		$display("partner words done");
		link_fault_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		chk({31'h0, tx_code_word_o[13]}, 32'h1);
		rd(32'h10, 32'h2041);
		link_fault_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk({16'h0, tx_code_word_o}, 32'h0041);
		$display("fault test done");
		rst_dut(1'b1);
		chk({29'h0, idle_symbols_o, an_enable_o, speed_100_o}, 32'h5);
		chk({31'h0, full_duplex_o}, 32'h1);
		rd(32'h10, 32'h0001);
		rd(32'h00, 32'h2100);
		rd(32'h14, 32'h0000);
		$display("forced mode done");
		tally_and_finish();
	end
endmodule
